/* File: rtl/baud_pkg.sv */
// package: register map, field positions and reset values of the baud divider block
`default_nettype none
package baud_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_BAUD_DIVISOR_HIGH = 4'h0;
    localparam logic [3:0] OFS_BAUD_DIVISOR_LOW  = 4'h4;
    localparam logic [3:0] OFS_CONTROL           = 4'h8;
    localparam logic [3:0] OFS_IRQ_STATUS        = 4'hc;
    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BRK_IRQ_EN_BIT  = 7;
    localparam int EDGE_IRQ_EN_BIT = 6;
    localparam int DIV_HIGH_MSB    = 4;
    localparam int CTL_RX_EN_BIT   = 0;
    localparam int CTL_TX_EN_BIT   = 1;
    localparam int CTL_PIN_SEL_BIT = 2;
    localparam int STS_BRK_BIT     = 0;
    localparam int STS_EDGE_BIT    = 1;
    localparam int DIV_WIDTH       = 13;
    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_DIV_HIGH = 8'h00;
    localparam logic [7:0] RST_DIV_LOW  = 8'h04;
    localparam logic [2:0] RST_CONTROL  = 3'h0;
    localparam logic [1:0] RST_STATUS   = 2'h0;
    localparam int         TICKS_PER_BIT = 16;
endpackage : baud_pkg
`default_nettype wire

/* File: rtl/rate_if.sv */
// interface: divisor and run control from the register file to the rate counter
`default_nettype none
interface rate_if;
    logic [12:0] divisor;
    logic        run;
    logic        tick;
    modport ctrl (output divisor, output run, input tick);
    modport gen  (input divisor, input run, output tick);
endinterface : rate_if
`default_nettype wire

/* File: rtl/rate_counter.sv */
// module: modulo counter producing the oversampling tick
`default_nettype none
module rate_counter
    import baud_pkg::*;
(
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    rate_if.gen       rif
);
    logic [12:0] cnt_ff;
    logic        tick_ff;

    // ------------------------------------------------------------------
    // counter: reloads every divisor cycles, held still at zero divisor
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_ff  <= 13'h0000;
            tick_ff <= 1'b0;
        end else if (!rif.run || rif.divisor == 13'h0000) begin // [RULE_03] [RULE_04]
            cnt_ff  <= 13'h0000;                                // no toggling saves current
            tick_ff <= 1'b0;
        end else if (cnt_ff >= rif.divisor - 13'h0001) begin    // [RULE_09] [RULE_05]
            cnt_ff  <= 13'h0000;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff  <= cnt_ff + 13'h0001;
            tick_ff <= 1'b0;
        end
    end

    assign rif.tick = tick_ff;
endmodule : rate_counter
`default_nettype wire

/* File: rtl/uart_baud_divider.sv */
// module: baud divisor registers, rate generator, event interrupts and pin placement
`default_nettype none
// Notes on behaviour
// RULE_01 - pin select 0 routes the second channel to port F bits 0 and 1, select 1 to port E bits 6 and 7.
// RULE_02 - a high byte write is only buffered and the whole divisor changes when the low byte is written.
// RULE_03 - after reset the generator stays stopped until receiver or transmitter enable is first written to 1.
// RULE_04 - a divisor of zero stops the generator entirely.
// RULE_05 - for divisors 1 to 8191 the bit rate is the bus clock over sixteen times the divisor.
// RULE_06 - divisor bits 12:8 live in high register bits 4:0 and bits 7:0 in the low register.
// RULE_07 - high register bit 7 lets the break-detect flag raise the interrupt.
// RULE_08 - high register bit 6 lets the receive-edge flag raise the interrupt.
// RULE_09 - a counter reloading every divisor cycles emits a one-cycle tick at sixteen times the bit rate.
module uart_baud_divider
    import baud_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        break_detect_event_i,
    input  wire logic        rx_edge_event_i,
    input  wire logic        second_transmit_line_i,
    output logic             second_receive_line_o,
    input  wire logic        port_f_bit_one_i,
    input  wire logic        port_e_bit_seven_i,
    output logic             port_f_bit_zero_o,
    output logic             port_f_bit_zero_oe_o,
    output logic             port_e_bit_six_o,
    output logic             port_e_bit_six_oe_o,
    output logic             oversample_tick_o,
    output logic             receiver_enable_o,
    output logic             transmitter_enable_o,
    output logic             irq_o
);
    import baud_pkg::*;

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0]  div_high_buf_ff;     // software visible high byte
    logic [4:0]  div_high_work_ff;    // working upper bits
    logic [7:0]  div_low_ff;
    logic        receiver_enable_ff;
    logic        transmitter_enable_ff;
    logic        pin_sel_ff;
    logic        started_ff;
    logic        break_detect_flag_ff;
    logic        rx_edge_flag_ff;
    logic        irq_ff;
    logic [31:0] rdata_ff;
    logic        wait_ff;
    logic        rx_line_ff;
    logic        tx_f_ff;
    logic        tx_e_ff;
    logic        oe_f_ff;
    logic        oe_e_ff;
    logic        tick_ff;

    rate_if rif ();

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    // one wait cycle per access keeps read data registered
    logic access;
    logic wr_go;
    logic rd_go;
    logic wr_lane0;
    assign access   = (avs_read_i || avs_write_i) && wait_ff;
    assign wr_go    = avs_write_i && wait_ff;
    assign rd_go    = avs_read_i && wait_ff;
    assign wr_lane0 = wr_go && avs_byteenable_i[0];

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // waitrequest: high at idle, low for exactly the answering cycle
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wait_ff <= 1'b1;
        end else if (access) begin
            wait_ff <= 1'b0;
        end else begin
            wait_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // divisor registers
    // ------------------------------------------------------------------
    // high write buffers only; working value follows a low write
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            div_high_buf_ff  <= RST_DIV_HIGH;
            div_high_work_ff <= RST_DIV_HIGH[DIV_HIGH_MSB:0];
            div_low_ff       <= RST_DIV_LOW;
        end else begin
            if (wr_lane0 && hit(avs_address_i, OFS_BAUD_DIVISOR_HIGH)) begin
                div_high_buf_ff <= {avs_writedata_i[7:6], 1'b0, avs_writedata_i[4:0]}; // [RULE_02] [RULE_06]
            end
            if (wr_lane0 && hit(avs_address_i, OFS_BAUD_DIVISOR_LOW)) begin
                div_low_ff       <= avs_writedata_i[7:0];                 // [RULE_06]
                div_high_work_ff <= div_high_buf_ff[DIV_HIGH_MSB:0];      // [RULE_02]
            end
        end
    end

    // ------------------------------------------------------------------
    // control register and generator start latch
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            receiver_enable_ff    <= RST_CONTROL[CTL_RX_EN_BIT];
            transmitter_enable_ff <= RST_CONTROL[CTL_TX_EN_BIT];
            pin_sel_ff            <= RST_CONTROL[CTL_PIN_SEL_BIT];
        end else if (wr_lane0 && hit(avs_address_i, OFS_CONTROL)) begin
            receiver_enable_ff    <= avs_writedata_i[CTL_RX_EN_BIT];
            transmitter_enable_ff <= avs_writedata_i[CTL_TX_EN_BIT];
            pin_sel_ff            <= avs_writedata_i[CTL_PIN_SEL_BIT];
        end
    end

    // once started it stays started until reset
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            started_ff <= 1'b0;
        end else if (wr_lane0 && hit(avs_address_i, OFS_CONTROL) &&
                     (avs_writedata_i[CTL_RX_EN_BIT] || avs_writedata_i[CTL_TX_EN_BIT])) begin
            started_ff <= 1'b1;                                           // [RULE_03]
        end
    end

    // ------------------------------------------------------------------
    // rate generator
    // ------------------------------------------------------------------
    assign rif.divisor = {div_high_work_ff, div_low_ff};                  // [RULE_06]
    assign rif.run     = started_ff;                                      // [RULE_03]

    rate_counter u_rate_counter (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .rif        (rif.gen)
    );

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= rif.tick;                                          // [RULE_09]
        end
    end

    // ------------------------------------------------------------------
    // event flags: write one to clear, a new event wins over the clear
    // ------------------------------------------------------------------
    logic clr_flags;
    assign clr_flags = wr_lane0 && hit(avs_address_i, OFS_IRQ_STATUS);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            break_detect_flag_ff <= RST_STATUS[STS_BRK_BIT];
        end else if (break_detect_event_i) begin
            break_detect_flag_ff <= 1'b1;
        end else if (clr_flags && avs_writedata_i[STS_BRK_BIT]) begin
            break_detect_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rx_edge_flag_ff <= RST_STATUS[STS_EDGE_BIT];
        end else if (rx_edge_event_i) begin
            rx_edge_flag_ff <= 1'b1;
        end else if (clr_flags && avs_writedata_i[STS_EDGE_BIT]) begin
            rx_edge_flag_ff <= 1'b0;
        end
    end

    // enables in the high byte act as the mask; flags stay pollable
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= (break_detect_flag_ff && div_high_buf_ff[BRK_IRQ_EN_BIT])  // [RULE_07]
                   || (rx_edge_flag_ff && div_high_buf_ff[EDGE_IRQ_EN_BIT]);     // [RULE_08]
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 32'h00000000;
        end else if (rd_go) begin
            case (avs_address_i)
                OFS_BAUD_DIVISOR_HIGH: rdata_ff <= {24'h000000, div_high_buf_ff};
                OFS_BAUD_DIVISOR_LOW:  rdata_ff <= {24'h000000, div_low_ff};
                OFS_CONTROL:           rdata_ff <= {29'h00000000, pin_sel_ff,
                                                    transmitter_enable_ff, receiver_enable_ff};
                OFS_IRQ_STATUS:        rdata_ff <= {30'h00000000, rx_edge_flag_ff, break_detect_flag_ff};
                default:               rdata_ff <= 32'h00000000;   // unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin placement of the second channel
    // ------------------------------------------------------------------
    // unselected port stays undriven so its general purpose use is free
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_f_ff    <= 1'b1;
            tx_e_ff    <= 1'b1;
            oe_f_ff    <= 1'b0;
            oe_e_ff    <= 1'b0;
            rx_line_ff <= 1'b1;
        end else begin
            tx_f_ff    <= second_transmit_line_i;
            tx_e_ff    <= second_transmit_line_i;
            oe_f_ff    <= !pin_sel_ff && transmitter_enable_ff;       // [RULE_01]
            oe_e_ff    <= pin_sel_ff && transmitter_enable_ff;        // [RULE_01]
            rx_line_ff <= pin_sel_ff ? port_e_bit_seven_i : port_f_bit_one_i; // [RULE_01]
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign avs_readdata_o        = rdata_ff;
    assign avs_waitrequest_o     = wait_ff;
    assign second_receive_line_o = rx_line_ff;
    assign port_f_bit_zero_o     = tx_f_ff;
    assign port_f_bit_zero_oe_o  = oe_f_ff;
    assign port_e_bit_six_o      = tx_e_ff;
    assign port_e_bit_six_oe_o   = oe_e_ff;
    assign oversample_tick_o     = tick_ff;
    assign receiver_enable_o     = receiver_enable_ff;
    assign transmitter_enable_o  = transmitter_enable_ff;
    assign irq_o                 = irq_ff;
endmodule : uart_baud_divider
`default_nettype wire

/* File: tb/uart_baud_divider_sva.sv */
// checker: bus handshake and pin placement properties of the baud divider
`default_nettype none
module uart_baud_divider_sva (
    input wire logic        core_clk_i,
    input wire logic        sys_rst_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o,
    input wire logic        second_transmit_line_i,
    input wire logic        port_f_bit_zero_o,
    input wire logic        port_f_bit_zero_oe_o,
    input wire logic        port_e_bit_six_o,
    input wire logic        port_e_bit_six_oe_o,
    input wire logic        transmitter_enable_o,
    input wire logic        oversample_tick_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------------
    // handshake: one wait state, never an answer without a request
    // ------------------------------------------------------------------
    a_bus_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("no answer one cycle after request");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_answer_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    a_rdata_hold: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
        else $error("read data changed without a read");
    // ------------------------------------------------------------------
    // pin placement: one position at a time, carrying the transmitter
    // ------------------------------------------------------------------
    a_pin_excl: assert property (!(port_f_bit_zero_oe_o && port_e_bit_six_oe_o))
        else $error("both pin positions driven");
    a_pin_needs_tx: assert property (port_f_bit_zero_oe_o || port_e_bit_six_oe_o |-> transmitter_enable_o)
        else $error("pin driven while transmitter off");
    a_route_f_tx: assert property (port_f_bit_zero_oe_o |-> port_f_bit_zero_o == $past(second_transmit_line_i))
        else $error("port f pin does not follow transmitter");
    a_route_e_tx: assert property (port_e_bit_six_oe_o |-> port_e_bit_six_o == $past(second_transmit_line_i))
        else $error("port e pin does not follow transmitter");
    c_tick: cover property (oversample_tick_o);
    c_irq: cover property ($rose(irq_o));
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : uart_baud_divider_sva
bind uart_baud_divider uart_baud_divider_sva i_uart_baud_divider_sva (.core_clk_i, .sys_rst_i, .avs_read_i,
    .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .second_transmit_line_i, .port_f_bit_zero_o,
    .port_f_bit_zero_oe_o, .port_e_bit_six_o, .port_e_bit_six_oe_o, .transmitter_enable_o, .oversample_tick_o,
    .irq_o);
`default_nettype wire

/* File: tb/serial_peer.sv */
// partner: remote transceiver driving the receive line at either pin position
`default_nettype none
module serial_peer (
    input  wire logic core_clk_i,
    input  wire logic sys_rst_i,
    input  wire logic e_drive_i,
    output logic      f_rx_o,
    output logic      e_rx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pat_ff;
    // level flips every cycle so a stale or misrouted sample shows up
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) pat_ff <= 1'b1;
        else pat_ff <= ~pat_ff;
    end
    // the unused position carries the inverse, not a copy
    assign f_rx_o = e_drive_i ? ~pat_ff : pat_ff;
    assign e_rx_o = e_drive_i ? pat_ff : ~pat_ff;
endmodule : serial_peer
`default_nettype wire

/* File: tb/test_uart_baud_divider.sv */
// testbench: register, rate, interrupt and pin placement tests of the baud divider
`default_nettype none
module test_uart_baud_divider;
    timeunit 1ns;
    timeprecision 1ns;
    import baud_pkg::*;
    logic        core_clk_i = 1'b0, sys_rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
    logic [3:0]  avs_address_i = 4'h0, avs_byteenable_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rdv;
    logic        break_detect_event_i = 1'b0, rx_edge_event_i = 1'b0, second_transmit_line_i = 1'b1;
    logic        avs_waitrequest_o, second_receive_line_o, port_f_bit_one_i, port_e_bit_seven_i;
    logic        port_f_bit_zero_o, port_f_bit_zero_oe_o, port_e_bit_six_o, port_e_bit_six_oe_o;
    logic        oversample_tick_o, receiver_enable_o, transmitter_enable_o, irq_o;
    int          fails = 0, checked = 0, cyc = 0;
    uart_baud_divider i_uart_baud_divider (.core_clk_i, .sys_rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
        .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .break_detect_event_i,
        .rx_edge_event_i, .second_transmit_line_i, .second_receive_line_o, .port_f_bit_one_i, .port_e_bit_seven_i,
        .port_f_bit_zero_o, .port_f_bit_zero_oe_o, .port_e_bit_six_o, .port_e_bit_six_oe_o, .oversample_tick_o,
        .receiver_enable_o, .transmitter_enable_o, .irq_o);
    serial_peer i_serial_peer (.core_clk_i, .sys_rst_i, .e_drive_i(port_e_bit_six_oe_o),
        .f_rx_o(port_f_bit_one_i), .e_rx_o(port_e_bit_seven_i));
    always #5 core_clk_i = ~core_clk_i;
    // hang guard, well above the longest rate measurement
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            summarize();
        end
    end
    // ------------------------------------------------------------------
    // compare and access tasks
    // ------------------------------------------------------------------
    task cmp_w(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: read %h, want %h", $time, got, exp);
        end
    endtask : cmp_w
    task cmp_b(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: pin %b, want %b", $time, got, exp);
        end
    endtask : cmp_b
    task cmp_n(input int got, input int exp);
        checked++;
        if (got != exp) begin
            fails++;
            $display("unexpected at %0t: count %0d, want %0d", $time, got, exp);
        end
    endtask : cmp_n
    // one idle edge first, so a strobe never gets two values in one step
    task acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
        @(posedge core_clk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_writedata_i <= {24'h0, d};
        avs_byteenable_i <= be;
        do @(posedge core_clk_i); while (avs_waitrequest_o !== 1'b0);
        rdv = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : acc
    task wr(input logic [3:0] a, input logic [7:0] d);
        acc(1'b1, a, d, 4'h1);
    endtask : wr
    task chk(input logic [3:0] a, input logic [31:0] exp);
        acc(1'b0, a, 8'h00, 4'hf);
        cmp_w(rdv, exp);
    endtask : chk
    // the first interval after a change may be partial, so skip it
    task period(input int exp);
        int n;
        n = 0;
        repeat (2) do @(posedge core_clk_i); while (oversample_tick_o !== 1'b1);
        do begin
            @(posedge core_clk_i);
            n++;
        end while (oversample_tick_o !== 1'b1);
        cmp_n(n, exp);
    endtask : period
    task quiet(input int k);
        int n;
        n = 0;
        repeat (4) @(posedge core_clk_i);
        repeat (k) begin
            @(posedge core_clk_i);
            if (oversample_tick_o !== 1'b0) n++;
        end
        cmp_n(n, 0);
    endtask : quiet
    task pulse(input int i);
        @(posedge core_clk_i);
        if (i == 0) break_detect_event_i <= 1'b1;
        else rx_edge_event_i <= 1'b1;
        @(posedge core_clk_i);
        break_detect_event_i <= 1'b0;
        rx_edge_event_i <= 1'b0;
    endtask : pulse
    task summarize();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        // reset contents, unmapped read, write without byte lane
        chk(OFS_BAUD_DIVISOR_HIGH, {24'h0, RST_DIV_HIGH});
        chk(OFS_BAUD_DIVISOR_LOW, {24'h0, RST_DIV_LOW});
        chk(OFS_IRQ_STATUS, 32'h0);
        chk(4'h1, 32'h0);
        acc(1'b1, OFS_CONTROL, 8'h03, 4'h0);
        chk(OFS_CONTROL, 32'h0);
        quiet(60);
        // start, buffered high byte, full 13-bit divisor, then zero
        wr(OFS_BAUD_DIVISOR_LOW, 8'h03);
        wr(OFS_CONTROL, 8'h02);
        cmp_b(transmitter_enable_o, 1'b1);
        period(3);
        wr(OFS_BAUD_DIVISOR_HIGH, 8'h01);
        period(3);
        wr(OFS_BAUD_DIVISOR_LOW, 8'h02);
        period(258);
        wr(OFS_BAUD_DIVISOR_HIGH, 8'h1f);
        wr(OFS_BAUD_DIVISOR_LOW, 8'hff);
        chk(OFS_BAUD_DIVISOR_HIGH, 32'h1f);
        period(8191);
        wr(OFS_BAUD_DIVISOR_HIGH, 8'h00);
        wr(OFS_BAUD_DIVISOR_LOW, 8'h00);
        quiet(60);
        // each event polled first, then unmasked, then cleared
        for (int i = 0; i < 2; i++) begin
            pulse(i);
            chk(OFS_IRQ_STATUS, 32'h1 << i);
            cmp_b(irq_o, 1'b0);
            wr(OFS_BAUD_DIVISOR_HIGH, 8'h80 >> i);
            repeat (2) @(posedge core_clk_i);
            cmp_b(irq_o, 1'b1);
            wr(OFS_IRQ_STATUS, 8'h01 << i);
            chk(OFS_IRQ_STATUS, 32'h0);
            cmp_b(irq_o, 1'b0);
            wr(OFS_BAUD_DIVISOR_HIGH, 8'h00);
        end
        // both pin positions, transmit level and receive sampling
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CONTROL, s ? 8'h07 : 8'h03);
            second_transmit_line_i <= s[0];
            repeat (3) @(posedge core_clk_i);
            #1;
            cmp_b(receiver_enable_o, 1'b1);
            cmp_b(port_f_bit_zero_oe_o, s == 0);
            cmp_b(port_e_bit_six_oe_o, s == 1);
            cmp_b(s ? port_e_bit_six_o : port_f_bit_zero_o, s[0]);
            cmp_b(second_receive_line_o, s ? ~port_e_bit_seven_i : ~port_f_bit_one_i);
        end
        summarize();
    end
endmodule : test_uart_baud_divider
`default_nettype wire
